// [src/esi_pkg.sv]
// Purpose: constants and carrier types for the E1 status, mask and counter block
// Assumes: 125 MHz system clock, byte registers on word-aligned Avalon addresses
// Notes:   register byte address is four times the register index
package esi_pkg;
  // register indexes, byte address = index * 4
  localparam logic [5:0] IDX_VC_HIGH  = 6'h00;
  localparam logic [5:0] IDX_VC_LOW   = 6'h01;
  localparam logic [5:0] IDX_CRC_HIGH = 6'h02;
  localparam logic [5:0] IDX_CRC_LOW  = 6'h03;
  localparam logic [5:0] IDX_ALARM    = 6'h06;
  localparam logic [5:0] IDX_EVENT    = 6'h07;
  localparam logic [5:0] IDX_AMASK    = 6'h16;
  localparam logic [5:0] IDX_EMASK    = 6'h17;
  localparam logic [5:0] IDX_CTRL     = 6'h20;
  // control register fields
  localparam int CTRL_FAST_POS  = 7; // fast_period_select
  localparam int CTRL_VTYPE_POS = 6; // violation_type_select
  localparam int CTRL_HDB3_POS  = 2; // rx_hdb3_enable
  localparam int CTRL_FORCE_POS = 0; // clock_loss_pin_force_enable
  // event status field positions
  localparam int EV_RX_CAS_MF  = 7;
  localparam int EV_RX_ALIGN   = 6;
  localparam int EV_TX_MF      = 5;
  localparam int EV_SECOND     = 4;
  localparam int EV_TX_ALIGN   = 3;
  localparam int EV_CLK_LOSS   = 2;
  localparam int EV_RX_CRC4_MF = 1;
  localparam int EV_TX_SLIP    = 0;
  // reset value, violation counter limit and hdb3 zero run
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] VC_MAX    = 16'hFFFF;
  localparam logic [5:0]  ZERO_RUN2 = 6'h02;
  // timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int SEC_PERIOD_MS  = 1000;
  localparam int FAST_PERIOD_US = 62500;
  localparam int CLK_LOSS_NS    = 3900;
  localparam int SEC_CYCLES  = SEC_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FAST_CYCLES = FAST_PERIOD_US * 1000 / CLK_PERIOD_NS;
  // least time: round up
  localparam int LOSS_CYCLES = (CLK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // timing strobes from framer and elastic store
  typedef struct packed {
    logic rx_cas_mf;   // receive multiframe boundary
    logic rx_align;    // receive align frame start
    logic tx_mf;       // transmit multiframe boundary
    logic tx_align;    // transmit align frame start
    logic rx_crc4_mf;  // receive crc4 multiframe boundary
    logic tx_slip;     // transmit slip occurred
  } esi_evt_s;
  // received line symbol
  typedef struct packed {
    logic valid;  // one bit time
    logic pos;    // positive mark
    logic neg;    // negative mark
  } esi_sym_s;
endpackage

// [src/esi_status_core.sv]
// Purpose: status flags, interrupt masks and error counters of the E1 receiver
// Assumes: strobes arrive on clock_i; transmit clock is asynchronous
// Notes:   flags are write-one-to-clear, a new event beats the clear
// Overview of operation
// - receive multiframe flag set each boundary
// - receive align frame flag each align frame
// - transmit multiframe flag each boundary
// - timer flag each second or 62.5ms
// - transmit align frame flag every 250us
// - clock loss flag after 3.9us idle
// - force pin high when loss and enabled
// - crc4 multiframe flag, 2ms when disabled
// - transmit slip flag on repeat or delete
// - alarm mask bit per alarm flag
// - event mask bit per event flag
// - counters update at each timer boundary
// - 16-bit counter of bipolar violations
// - hdb3 codewords excluded from bipolar count
// - select bit chooses code violation counting
// - violation counter saturates, never rolls
// - 10-bit crc4 error counter
// - crc count halts on fas/crc4 loss
// - violation count high byte 00, low 01
// - event status at 07, fixed bit order
// - alarm status at 06, fixed bit order
// - crc count high bits 02, low 03
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module esi_status_core
  import esi_pkg::*;
#(
  parameter int SEC_COUNT  = SEC_CYCLES,  // one second in cycles
  parameter int FAST_COUNT = FAST_CYCLES  // 62.5ms in cycles
)(
  input  wire logic        clock_i,       // system clock
  input  wire logic        reset_i,       // async reset, high
  input  wire logic        clk_en_i,      // freezes all state when low
  input  wire logic [7:0]  avs_address,   // byte address
  input  wire logic        avs_read,      // read request
  input  wire logic        avs_write,     // write request
  input  wire logic [31:0] avs_writedata, // write data
  input  wire logic [3:0]  avs_byteenable,// lane enables
  output logic [31:0]      avs_readdata,  // read data
  output logic             avs_waitrequest,// stall
  input  wire esi_evt_s    evt_i,         // timing strobes
  input  wire logic        crc4_mode_i,   // crc4 framing on
  input  wire logic [7:0]  alarm_i,       // alarm set pulses
  input  wire esi_sym_s    sym_i,         // line symbols
  input  wire logic        crc_error_i,   // crc4 codeword error
  input  wire logic        fas_sync_lost_i,  // fas level loss
  input  wire logic        crc4_sync_lost_i, // crc4 level loss
  input  wire logic        transmit_clock_input, // async tx clock
  output logic             clock_loss_pin_o, // forced high pin
  output logic             irq_o          // interrupt request
);
  // register state
  logic [7:0]  alarm_status;        // sticky alarm flags
  logic [7:0]  timing_event_status; // sticky event flags
  logic [7:0]  alarm_interrupt_mask;
  logic [7:0]  event_interrupt_mask;
  logic [7:0]  ctrl;                // own control bits
  logic        resp;                // answer cycle
  // counters
  logic [26:0] tmr;                 // period timer
  logic [15:0] vc_run;              // running violations
  logic [15:0] violation_counter;   // held violations
  logic [9:0]  crc_run;             // running crc errors
  logic [9:0]  crc_count;           // held crc errors
  logic [8:0]  loss_cnt;            // tx clock idle time
  // line decode state
  logic        last_pol;            // polarity of last mark
  logic        have_mark;
  logic        last_bpv_pol;        // polarity of last bpv
  logic        have_bpv;
  logic [5:0]  zrun;                // zeros since mark
  // tx clock synchroniser
  logic        tcs1;
  logic        tcs2;
  logic        tcs3;
  logic        tc_level;            // accepted level

  // control bits
  wire fast_period_select    = ctrl[CTRL_FAST_POS];
  wire violation_type_select = ctrl[CTRL_VTYPE_POS];
  wire rx_hdb3_enable        = ctrl[CTRL_HDB3_POS];
  wire clock_loss_pin_force_enable = ctrl[CTRL_FORCE_POS];

  // bus decode
  wire       req     = avs_read | avs_write;
  wire [5:0] idx     = avs_address[7:2];
  wire       do_wr   = clk_en_i & resp & avs_write & avs_byteenable[0];
  wire [7:0] wbyte   = avs_writedata[7:0];
  wire       wr_alm  = do_wr & (idx == IDX_ALARM);
  wire       wr_evt  = do_wr & (idx == IDX_EVENT);
  wire       wr_am   = do_wr & (idx == IDX_AMASK);
  wire       wr_em   = do_wr & (idx == IDX_EMASK);
  wire       wr_ctl  = do_wr & (idx == IDX_CTRL);
  assign avs_waitrequest = req & ~resp;

  // timer boundary
  wire [26:0] period  = fast_period_select ? 27'(FAST_COUNT) : 27'(SEC_COUNT);
  wire        tmr_end = (tmr == period - 27'h1) | (tmr >= period);
  wire        tick    = clk_en_i & tmr_end;

  // violation classification
  wire mark   = sym_i.valid & (sym_i.pos ^ sym_i.neg);
  wire bpv    = mark & have_mark & (sym_i.pos == last_pol);
  wire hdb3cw = rx_hdb3_enable & (zrun >= ZERO_RUN2);
  wire cv     = bpv & have_bpv & (sym_i.pos == last_bpv_pol);
  wire v_evt  = violation_type_select ? cv : (bpv & ~hdb3cw);
  wire vc_sat = (vc_run == VC_MAX);

  // crc counting allowed
  wire crc_evt = crc_error_i & ~fas_sync_lost_i & ~crc4_sync_lost_i;

  // tx clock transition and loss
  wire tc_edge   = (tcs2 == tcs3) & (tcs3 != tc_level);
  wire loss_hit  = (loss_cnt == 9'(LOSS_CYCLES - 1)) & ~tc_edge;

  // event set vector
  wire crc4_mf_src = crc4_mode_i ? evt_i.rx_crc4_mf : evt_i.rx_cas_mf;
  wire [7:0] ev_set = {evt_i.rx_cas_mf,
                       evt_i.rx_align,
                       evt_i.tx_mf,
                       tmr_end,
                       evt_i.tx_align,
                       loss_hit,
                       crc4_mf_src,
                       evt_i.tx_slip};

  // next flag values, set beats clear
  wire [7:0] next_alarm = (alarm_status & ~(wr_alm ? wbyte : 8'h00)) | alarm_i;
  wire [7:0] next_event =
    (timing_event_status & ~(wr_evt ? wbyte : 8'h00)) | ev_set;

  // read mux
  logic [7:0] rbyte;
  always_comb
  begin
    unique case (idx)
      IDX_VC_HIGH:  rbyte = violation_counter[15:8];
      IDX_VC_LOW:   rbyte = violation_counter[7:0];
      IDX_CRC_HIGH: rbyte = {6'h00, crc_count[9:8]};
      IDX_CRC_LOW:  rbyte = crc_count[7:0];
      IDX_ALARM:    rbyte = alarm_status;
      IDX_EVENT:    rbyte = timing_event_status;
      IDX_AMASK:    rbyte = alarm_interrupt_mask;
      IDX_EMASK:    rbyte = event_interrupt_mask;
      IDX_CTRL:     rbyte = ctrl;
      default:      rbyte = 8'h00;                    // unmapped
    endcase
  end

  // bus handshake, one wait cycle
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      resp         <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else if (clk_en_i)
    begin
      resp         <= req & ~resp;
      avs_readdata <= {24'h00_0000, rbyte};
    end
  end

  // writable registers and flags
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      alarm_status         <= RST_BYTE;
      timing_event_status  <= RST_BYTE;
      alarm_interrupt_mask <= RST_BYTE;
      event_interrupt_mask <= RST_BYTE;
      ctrl                 <= RST_BYTE;
    end
    else if (clk_en_i)
    begin
      alarm_status        <= next_alarm;
      timing_event_status <= next_event;
      if (wr_am)
        alarm_interrupt_mask <= wbyte;
      if (wr_em)
        event_interrupt_mask <= wbyte;
      if (wr_ctl)
        ctrl <= wbyte;
    end
  end

  // period timer and counter update
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tmr               <= 27'h000_0000;
      vc_run            <= 16'h0000;
      violation_counter <= 16'h0000;
      crc_run           <= 10'h000;
      crc_count         <= 10'h000;
    end
    else if (clk_en_i)
    begin
      if (tmr_end)
      begin
        tmr               <= 27'h000_0000;
        violation_counter <= vc_run;
        crc_count         <= crc_run;
        vc_run            <= {15'h0000, v_evt};
        crc_run           <= {9'h000, crc_evt};
      end
      else
      begin
        tmr <= tmr + 27'h1;
        if (v_evt & ~vc_sat)
          vc_run <= vc_run + 16'h1;
        if (crc_evt)
          crc_run <= crc_run + 10'h1;
      end
    end
  end

  // line polarity tracking
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      last_pol     <= 1'b0;
      have_mark    <= 1'b0;
      last_bpv_pol <= 1'b0;
      have_bpv     <= 1'b0;
      zrun         <= 6'h00;
    end
    else if (clk_en_i & sym_i.valid)
    begin
      if (mark)
      begin
        last_pol  <= sym_i.pos;
        have_mark <= 1'b1;
        zrun      <= 6'h00;
      end
      else if (zrun != 6'h3F)
        zrun <= zrun + 6'h01;
      if (bpv)
      begin
        last_bpv_pol <= sym_i.pos;
        have_bpv     <= 1'b1;
      end
    end
  end

  // tx clock sync and idle watch
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tcs1     <= 1'b0;
      tcs2     <= 1'b0;
      tcs3     <= 1'b0;
      tc_level <= 1'b0;
      loss_cnt <= 9'h000;
    end
    else if (clk_en_i)
    begin
      tcs1 <= transmit_clock_input;
      tcs2 <= tcs1;
      tcs3 <= tcs2;
      if (tc_edge)
      begin
        tc_level <= tcs3;
        loss_cnt <= 9'h000;
      end
      else if (loss_cnt != 9'(LOSS_CYCLES - 1))
        loss_cnt <= loss_cnt + 9'h001;
    end
  end

  // outputs
  assign clock_loss_pin_o = timing_event_status[EV_CLK_LOSS]
                          & clock_loss_pin_force_enable;
  assign irq_o = |(alarm_status & alarm_interrupt_mask)
               | |(timing_event_status & event_interrupt_mask);

  // checks, all on the one system clock
  // reset masks every property, so no check sees reset-time values
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  property p_rx_mf;
    clk_en_i & evt_i.rx_cas_mf |=> timing_event_status[EV_RX_CAS_MF];
  endproperty
  a_rx_mf: assert property (p_rx_mf) else $error("rx mf flag missed");

  property p_tx_slip;
    clk_en_i & evt_i.tx_slip |=> timing_event_status[EV_TX_SLIP];
  endproperty
  a_tx_slip: assert property (p_tx_slip) else $error("slip flag missed");

  property p_sec;
    tick |=> timing_event_status[EV_SECOND] && tmr == 27'h0;
  endproperty
  a_sec: assert property (p_sec) else $error("timer flag missed");

  property p_update;
    tick |=> violation_counter == $past(vc_run) && vc_run <= 16'h1;
  endproperty
  a_update: assert property (p_update) else $error("count update wrong");

  property p_sat;
    clk_en_i & vc_sat & ~tmr_end |=> vc_sat;
  endproperty
  a_sat: assert property (p_sat) else $error("violation rollover");

  property p_crc_hold;
    clk_en_i & ~tmr_end & (fas_sync_lost_i | crc4_sync_lost_i)
      |=> crc_run == $past(crc_run);
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("crc counted");

  property p_loss;
    clk_en_i & loss_hit |=> timing_event_status[EV_CLK_LOSS];
  endproperty
  a_loss: assert property (p_loss) else $error("loss flag missed");

  // idle tx clock reaches the pin through the flag register
  property p_pin;
    clk_en_i & loss_hit & clock_loss_pin_force_enable & ~wr_ctl
      |=> clock_loss_pin_o;
  endproperty
  a_pin: assert property (p_pin) else $error("pin not forced");

  property p_irq;
    clk_en_i & |(ev_set & event_interrupt_mask) & ~wr_em |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_wait;
    clk_en_i & req & ~resp |=> ~avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus stalled");

  // a set pulse always lands in its alarm flag
  property p_alarm;
    clk_en_i & (|alarm_i) |=> (alarm_status & $past(alarm_i)) == $past(alarm_i);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm flag missed");

  // a written event mask byte is taken whole
  property p_mask;
    wr_em |=> event_interrupt_mask == $past(wbyte);
  endproperty
  a_mask: assert property (p_mask) else $error("mask not written");

  // a counted crc error away from a boundary adds exactly one
  property p_crc_count;
    clk_en_i & ~tmr_end & crc_evt |=> crc_run == $past(crc_run) + 10'h1;
  endproperty
  a_crc_count: assert property (p_crc_count) else $error("crc count wrong");

  // held violation count changes only at a boundary
  property p_hold;
    ~tick |=> $stable(violation_counter);
  endproperty
  a_hold: assert property (p_hold) else $error("held count moved");

  // main scenarios reached
  c_tick: cover property (tick);
  c_fast: cover property (tick & fast_period_select);
  c_sat: cover property (vc_sat);
  c_loss: cover property (clock_loss_pin_o);
  c_irq: cover property (irq_o ##1 ~irq_o);
endmodule
`default_nettype wire

// [tb/esi_host_model.sv]
// Purpose: host processor model that reaches the registers over the bus
// Assumes: one transfer at a time, the slave adds wait states
// Notes:   after time zero, signals change only by non-blocking assignment after a rising edge
`timescale 1ns/100ps
`default_nettype none
module esi_host_model
  import esi_pkg::*;
(
  input  wire logic        clock_i,        // system clock
  output logic [7:0]       avs_address,    // byte address
  output logic             avs_read,       // read strobe
  output logic             avs_write,      // write strobe
  output logic [31:0]      avs_writedata,  // write data
  output logic [3:0]       avs_byteenable, // lane enables
  input  wire logic [31:0] avs_readdata,   // read data
  input  wire logic        avs_waitrequest // stall
);
  // bus idle at time zero
  initial
  begin
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h00000000;
    avs_byteenable = 4'h1;
  end
  // one access, held until the rising edge that sees waitrequest low;
  // counters are read soon after the timer flag, before the next boundary
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clock_i);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_read      <= !w;
    avs_write     <= w;
    // stall is read as the edge samples it, before that edge's updates
    do
      @(posedge clock_i);
    while (avs_waitrequest !== 1'b0);
    // data taken and request dropped at the very edge that ends the wait
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/e1_status_irq_and_error_counters_bench.sv]
// Purpose: self-checking bench for the status, mask and counter block
// Assumes: shortened timer periods of 200 and 50 cycles
// Notes: violation mode per period is chosen to suit the line code
`timescale 1ns/100ps
`default_nettype none
module e1_status_irq_and_error_counters_bench
  import esi_pkg::*;
;
  `define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s expected %h seen %h", n, e, g); end end
  localparam logic [7:0] VH = {IDX_VC_HIGH, 2'b00};  // byte addresses
  localparam logic [7:0] VL = {IDX_VC_LOW, 2'b00};
  localparam logic [7:0] CH = {IDX_CRC_HIGH, 2'b00};
  localparam logic [7:0] CL = {IDX_CRC_LOW, 2'b00};
  localparam logic [7:0] AL = {IDX_ALARM, 2'b00};
  localparam logic [7:0] EV = {IDX_EVENT, 2'b00};
  localparam logic [7:0] AM = {IDX_AMASK, 2'b00};
  localparam logic [7:0] EM = {IDX_EMASK, 2'b00};
  localparam logic [7:0] CT = {IDX_CTRL, 2'b00};
  // status bit raised by each strobe, struct lsb first
  function automatic logic [7:0] exp_bit(input int i);
    case (i)
      0:       exp_bit = 8'h01;
      1:       exp_bit = 8'h02;
      2:       exp_bit = 8'h08;
      3:       exp_bit = 8'h20;
      4:       exp_bit = 8'h40;
      default: exp_bit = 8'h80;
    endcase
  endfunction
  logic        clock_i, reset_i;       // clock and reset
  esi_evt_s    evt;                    // timing strobes
  esi_sym_s    sym;                    // line symbols
  logic        crc4_mode, crc_err;     // crc4 inputs
  logic        fas_lost, crc4_lost;    // sync loss levels
  logic [7:0]  alarm;                  // alarm set inputs
  logic        txclk, tx_run;          // transmit clock and its gate
  logic [1:0]  tx_div;                 // transmit clock divider
  logic        ce;                     // clock enable
  logic        pin, irq;               // forced pin, interrupt
  logic [7:0]  adr;                    // bus address
  logic        rd_s, wr_s, wreq;       // bus strobes and stall
  logic [31:0] wdat, rdat;             // bus data
  logic [3:0]  be;                     // lane enables
  logic [7:0]  q;                      // last read byte
  int          fail_count, check_count; // verdict counters
  // 125 MHz clock
  always #4 clock_i = ~clock_i;
  // transmit clock runs only while enabled, one change per four cycles
  // so the synchroniser sees each level four times
  always @(posedge clock_i)
    if (tx_run)
    begin
      tx_div <= tx_div + 2'h1;
      if (tx_div == 2'h3)
        txclk <= ~txclk;
    end
  esi_host_model H (.clock_i(clock_i), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
    .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq));
  esi_status_core #(.SEC_COUNT(200), .FAST_COUNT(50)) DUT (.clock_i(clock_i),
    .reset_i(reset_i), .clk_en_i(ce), .avs_address(adr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .evt_i(evt), .crc4_mode_i(crc4_mode), .alarm_i(alarm),
    .sym_i(sym), .crc_error_i(crc_err), .fas_sync_lost_i(fas_lost),
    .crc4_sync_lost_i(crc4_lost), .transmit_clock_input(txclk),
    .clock_loss_pin_o(pin), .irq_o(irq));
  // register read and write
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    H.acc(1'b0, a, 8'h00, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    H.acc(1'b1, a, d, x);
  endtask
  // clear the timer flag, wait for the next one, clear again
  task automatic sync_sec;
    logic [7:0] x;
    wr(EV, 8'h10);
    x = 8'h00;
    while (x[EV_SECOND] !== 1'b1)
      rd(EV, x);
    wr(EV, 8'h10);
  endtask
  // eight symbols, two bits each {pos,neg}, first symbol in the top bits
  task automatic syms(input logic [15:0] v);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge clock_i);
      sym <= {1'b1, v[2*i+1], v[2*i]};
    end
    @(posedge clock_i);
    sym <= 3'h0;
  endtask
  // crc error pulses, one per two cycles
  task automatic pulse_crc(input int n);
    repeat (n)
    begin
      @(posedge clock_i);
      crc_err <= 1'b1;
      @(posedge clock_i);
      crc_err <= 1'b0;
    end
  endtask
  // one timer period of errors, then read the held counts
  task automatic count_run(input logic [7:0] c, input logic [7:0] vc);
    wr(CT, c);
    syms(16'h5000);
    sync_sec;
    syms(16'hA824);
    pulse_crc(5);
    fas_lost <= 1'b1;
    pulse_crc(2);
    fas_lost  <= 1'b0;
    crc4_lost <= 1'b1;
    pulse_crc(2);
    crc4_lost <= 1'b0;
    sync_sec;
    rd(VH, q); `CHK("vc_high", 8'h00, q)
    rd(VL, q); `CHK("vc_low", vc, q)
    rd(CH, q); `CHK("crc_high", 8'h00, q)
    rd(CL, q); `CHK("crc_low", 8'h05, q)
  endtask
  // print counts and verdict, end the run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    wrap_up;
  end
  // main sequence
  initial
  begin
    {clock_i, evt, sym, crc_err, fas_lost, crc4_lost, alarm, txclk, tx_div} = '0;
    {reset_i, crc4_mode, tx_run, ce} = 4'hF;
    fail_count  = 0;
    check_count = 0;
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    // reset values, unmapped place, masks read back
    rd(EM, q); `CHK("emask_rst", 8'h00, q)
    rd(8'hFC, q); `CHK("unmapped", 8'h00, q)
    wr(EM, 8'hA5); rd(EM, q); `CHK("emask", 8'hA5, q)
    wr(AM, 8'h5A); rd(AM, q); `CHK("amask", 8'h5A, q)
    wr(AM, 8'h00);
    // every strobe sets its own flag, interrupt follows the mask
    for (int i = 0; i < 6; i++)
    begin
      wr(EM, exp_bit(i));
      @(posedge clock_i);
      evt <= esi_evt_s'(6'h01 << i);
      @(posedge clock_i);
      evt <= 6'h00;
      rd(EV, q);
      @(negedge clock_i);
      `CHK("event", exp_bit(i), q & exp_bit(i))
      `CHK("irq_on", 1'b1, irq)
      wr(EV, exp_bit(i));
      @(negedge clock_i);
      `CHK("irq_off", 1'b0, irq)
    end
    // crc4 off: the multiframe strobe also marks the crc4 boundary
    @(posedge clock_i);
    crc4_mode <= 1'b0;
    wr(EM, 8'h00);
    wr(EV, 8'hFF);
    @(posedge clock_i);
    evt <= esi_evt_s'(6'h20);
    @(posedge clock_i);
    evt <= 6'h00;
    rd(EV, q); `CHK("crc4_mf", 8'h82, q & 8'h82)
    crc4_mode <= 1'b1;
    // clock enable low: a strobe in that cycle is not taken
    @(posedge clock_i);
    ce  <= 1'b0;
    evt <= esi_evt_s'(6'h01);
    @(posedge clock_i);
    evt <= 6'h00;
    ce  <= 1'b1;
    rd(EV, q); `CHK("frozen", 1'b0, q[EV_TX_SLIP])
    // alarm flags and their mask
    @(posedge clock_i);
    alarm <= 8'h81;
    @(posedge clock_i);
    alarm <= 8'h00;
    rd(AL, q); `CHK("alarm", 8'h81, q)
    @(negedge clock_i);
    `CHK("irq_masked", 1'b0, irq)
    wr(AM, 8'h80);
    @(negedge clock_i);
    `CHK("irq_alarm", 1'b1, irq)
    wr(AL, 8'h81);
    @(negedge clock_i);
    `CHK("irq_clear", 1'b0, irq)
    wr(AM, 8'h00);
    // timer period, slow then fast
    sync_sec;
    repeat (60) @(posedge clock_i);
    rd(EV, q); `CHK("slow_sec", 1'b0, q[EV_SECOND])
    wr(CT, 8'h80);
    sync_sec;
    repeat (60) @(posedge clock_i);
    rd(EV, q); `CHK("fast_sec", 1'b1, q[EV_SECOND])
    // transmit clock stops, flag and forced pin
    wr(CT, 8'h00);
    tx_run <= 1'b0;
    repeat (520) @(posedge clock_i);
    rd(EV, q); `CHK("clk_loss", 1'b1, q[EV_CLK_LOSS])
    @(negedge clock_i);
    `CHK("pin_off", 1'b0, pin)
    wr(CT, 8'h01);
    @(negedge clock_i);
    `CHK("pin_on", 1'b1, pin)
    tx_run <= 1'b1;
    repeat (16) @(posedge clock_i);
    wr(EV, 8'h04);
    rd(EV, q); `CHK("clk_back", 1'b0, q[EV_CLK_LOSS])
    @(negedge clock_i);
    `CHK("pin_back", 1'b0, pin)
    // violation counting modes, fresh count each period
    count_run(8'h00, 8'h03);
    count_run(8'h04, 8'h02);
    count_run(8'h40, 8'h02);
    wrap_up;
  end
endmodule
`default_nettype wire
